// ### src/afs_pkg.sv
// Package with the constants, types and state codes of the almost-full flag bus scanner.
//
// Contract
// - Mode pin sampled at reset: high polled.
// - Direct: strobe edge shows addressed quadrant.
// - Polled: one quadrant per edge, wrap.
// - Sync high only while quadrant one shown.
// - Token pulses when final quadrant loaded.
// - Token input starts own quadrant sequence.
// - Address: 3-bit device, 5-bit queue.
// - Respond only when upper address matches identity.
// - Identity captured at reset, held stable.
// - Any identity order, master any identity.
package afs_pkg;

  // Queue address layout.
  localparam int AFS_ADDR_W = 8;
  localparam int AFS_ID_W = 3;
  localparam int AFS_QIDX_W = 5;
  localparam int AFS_ID_LSB = 5;
  localparam int AFS_QUAD_LSB = 3;

  // Flag bus geometry.
  localparam int AFS_FLAG_BUS_W = 8;
  localparam int AFS_NUM_QUADS = 4;
  localparam int AFS_QUAD_W = 2;
  localparam logic [1:0] AFS_QUAD_FIRST = 2'h0;
  localparam logic [1:0] AFS_QUAD_LAST = 2'h3;

  // Edges after reset release until the strap synchronisers hold pin values.
  localparam logic [1:0] AFS_STRAP_SETTLE = 2'h2;

  // Width of the synchronised pin bundle: mode, master, strobe, identity and both addresses.
  localparam int AFS_PIN_W = 3 + AFS_ID_W + 2 * AFS_ADDR_W;

  // Straps captured once after master reset.
  typedef struct packed {
    logic polled;
    logic master;
    logic [AFS_ID_W-1:0] id;
  } afs_straps_t;

  // Result of a queue address decode.
  typedef struct packed {
    logic hit;
    logic [AFS_QIDX_W-1:0] index;
  } afs_qsel_t;

  // Polled scan states, one-hot.
  typedef enum logic [1:0] {
    AFS_ST_WAIT = 2'b01,
    AFS_ST_SCAN = 2'b10
  } afs_scan_state_t;

endpackage

// ### src/afs_sync2.sv
// Two-flop synchroniser for a bundle of static or slow pin levels.
`timescale 1ns/1ps
module afs_sync2 #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Pin levels and their synchronised copy.
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta;

  // The first stage feeds only the second stage, to keep metastability contained.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule // afs_sync2

// ### src/afs_addr_decode.sv
// Registered queue address decoder that compares the device field with the identity.
`timescale 1ns/1ps
module afs_addr_decode import afs_pkg::*; (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Address, identity and enable.
  input wire logic [AFS_ADDR_W-1:0] i_addr,
  input wire logic [AFS_ID_W-1:0] i_id,
  input wire logic i_en,
  // Decoded selection.
  output afs_qsel_t o_sel
);

  // Upper bits pick the device, lower bits the queue inside it.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sel <= '0;
    end else begin
      o_sel.hit <= i_en && (i_addr[AFS_ADDR_W-1:AFS_ID_LSB] == i_id);
      o_sel.index <= i_addr[AFS_QIDX_W-1:0];
    end
  end

  property p_dec_match;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_en && i_addr[AFS_ADDR_W-1:AFS_ID_LSB] == i_id) |=>
        (o_sel.hit && o_sel.index == $past(i_addr[AFS_QIDX_W-1:0]));
  endproperty
  a_dec_match: assert property (p_dec_match) else $error("Matching address not selected.");

  property p_dec_miss;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_addr[AFS_ADDR_W-1:AFS_ID_LSB] != i_id) |=> !o_sel.hit;
  endproperty
  a_dec_miss: assert property (p_dec_miss) else $error("Foreign address selected.");

endmodule // afs_addr_decode

// ### src/afs_flag_scan.sv
// Almost-full flag bus scanner: direct and polled quadrant display with token chaining.
`timescale 1ns/1ps
module afs_flag_scan import afs_pkg::*; #(
  parameter int FLAG_W = AFS_FLAG_BUS_W,
  parameter int QUADS = AFS_NUM_QUADS
) (
  // Clock and master reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Straps, sampled after master reset.
  input wire logic i_flag_bus_mode_sel,
  input wire logic i_master_device,
  input wire logic [AFS_ID_W-1:0] i_chain_identity_pins,
  // Flag bus pins.
  input wire logic i_full_side_quadrant_strobe,
  input wire logic i_full_side_token_in,
  // Queue address buses.
  input wire logic [AFS_ADDR_W-1:0] i_write_queue_addr,
  input wire logic [AFS_ADDR_W-1:0] i_read_queue_addr,
  // Internal status from the queue core, same clock.
  input wire logic [FLAG_W*QUADS-1:0] i_almost_full_flags,
  input wire logic i_program_done,
  // Flag bus outputs.
  output logic [FLAG_W-1:0] o_almost_full_status_bus,
  output logic o_almost_full_bus_own,
  output logic o_full_side_scan_sync,
  output logic o_full_side_token_out,
  // Mode and queue selection for the rest of the device.
  output logic o_polled_mode,
  output afs_qsel_t o_write_sel,
  output afs_qsel_t o_read_sel
);

  // Elaboration check: the scan sequencer and quadrant field are fixed at four quadrants.
  if (QUADS != AFS_NUM_QUADS || FLAG_W < 1) begin : g_bad_param
    $error("afs_flag_scan supports exactly four quadrants and a nonzero bus width.");
  end

  // Synchronised pins.
  logic [AFS_PIN_W-1:0] pins_raw;
  logic [AFS_PIN_W-1:0] pins_s;
  logic mode_s;
  logic master_s;
  logic [AFS_ID_W-1:0] id_s;
  logic strobe_s;
  logic [AFS_ADDR_W-1:0] waddr_s;
  logic [AFS_ADDR_W-1:0] raddr_s;

  // Captured straps.
  logic [1:0] settle;
  logic straps_valid;
  afs_straps_t straps;

  // Scan control.
  afs_scan_state_t state;
  afs_scan_state_t next_state;
  logic [AFS_QUAD_W-1:0] shown_quad;
  logic [AFS_QUAD_W-1:0] next_shown_quad;
  logic token_prev;
  logic token_rise;
  logic master_kick_done;
  logic scan_start;
  logic strobe_d;
  logic dir_load;
  logic [FLAG_W-1:0] quad_flags [QUADS];

  // The token comes from a neighbour on this same clock, so it skips the synchroniser;
  // that keeps the handoff to one edge and lets a looped device wrap without a gap.
  assign pins_raw = {i_flag_bus_mode_sel, i_master_device, i_chain_identity_pins,
                     i_full_side_quadrant_strobe,
                     i_write_queue_addr, i_read_queue_addr};

  // Slow pins cross two flops; this adds two cycles of latency to the strobe.
  afs_sync2 #(.W(AFS_PIN_W)) u_pin_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async(pins_raw),
    .o_sync(pins_s)
  );

  assign {mode_s, master_s, id_s, strobe_s, waddr_s, raddr_s} = pins_s;

  // Count edges after release so that the synchronisers hold real pin levels.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      settle <= '0;
    end else if (settle != AFS_STRAP_SETTLE) begin
      settle <= settle + 2'h1;
    end
  end

  // Straps are taken once; later pin changes are ignored by design.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      straps <= '0;
      straps_valid <= 1'b0;
    end else if (!straps_valid && settle == AFS_STRAP_SETTLE) begin
      straps.polled <= mode_s;
      straps.master <= master_s;
      straps.id <= id_s;
      straps_valid <= 1'b1;
    end
  end

  // Write and read address decoders; any identity value 0..7 is accepted.
  afs_addr_decode u_wr_dec (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_addr(waddr_s),
    .i_id(straps.id),
    .i_en(straps_valid),
    .o_sel(o_write_sel)
  );

  afs_addr_decode u_rd_dec (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_addr(raddr_s),
    .i_id(straps.id),
    .i_en(straps_valid),
    .o_sel(o_read_sel)
  );

  // Split the flag vector into quadrants of one bus width each.
  for (genvar q = 0; q < QUADS; q++) begin : g_quad
    assign quad_flags[q] = i_almost_full_flags[q*FLAG_W +: FLAG_W];
  end

  // Token edge detect and one-time master kick that starts the first scan.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      token_prev <= 1'b0;
      master_kick_done <= 1'b0;
    end else begin
      token_prev <= i_full_side_token_in;
      if (scan_start) begin
        master_kick_done <= 1'b1;
      end
    end
  end

  assign token_rise = i_full_side_token_in && !token_prev;
  // A token from the preceding device, or the master's own kick, starts a scan.
  assign scan_start = straps_valid && straps.polled && (state == AFS_ST_WAIT) &&
                      (token_rise || (straps.master && !master_kick_done));

  // Strobe is delayed one cycle to line up with the registered write decode.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      strobe_d <= 1'b0;
    end else begin
      strobe_d <= strobe_s;
    end
  end

  // Direct selection waits for programming to finish; strobe_d is ignored while i_program_done is low.
  assign dir_load = straps_valid && !straps.polled && strobe_d && i_program_done;

  // Next state and next quadrant of the scan.
  always_comb begin
    next_state = state;
    next_shown_quad = shown_quad;
    case (state)
      AFS_ST_WAIT: begin
        if (scan_start) begin
          next_state = AFS_ST_SCAN;
          next_shown_quad = AFS_QUAD_FIRST;
        end else if (dir_load && o_write_sel.hit) begin
          next_shown_quad = o_write_sel.index[AFS_QIDX_W-1:AFS_QUAD_LSB];
        end
      end
      AFS_ST_SCAN: begin
        next_shown_quad = shown_quad + 2'h1;
        if (next_shown_quad == AFS_QUAD_LAST) begin
          next_state = AFS_ST_WAIT;
        end
      end
      default: begin
        next_state = AFS_ST_WAIT;
        next_shown_quad = AFS_QUAD_FIRST;
      end
    endcase
  end

  // Scan state and shown quadrant registers.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= AFS_ST_WAIT;
      shown_quad <= AFS_QUAD_FIRST;
    end else begin
      state <= next_state;
      shown_quad <= next_shown_quad;
    end
  end

  // The bus refreshes every edge so that live flag changes of the shown quadrant appear.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_almost_full_status_bus <= '0;
    end else begin
      o_almost_full_status_bus <= quad_flags[next_shown_quad];
    end
  end

  // Sync marks quadrant one, token marks the last; each lasts one cycle.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_full_side_scan_sync <= 1'b0;
      o_full_side_token_out <= 1'b0;
    end else begin
      o_full_side_scan_sync <= scan_start;
      o_full_side_token_out <= (state == AFS_ST_SCAN) &&
                               (next_shown_quad == AFS_QUAD_LAST);
    end
  end

  // Bus ownership: the selected device in direct mode, or during its own four quadrants.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_almost_full_bus_own <= 1'b0;
      o_polled_mode <= 1'b0;
    end else begin
      o_polled_mode <= straps_valid && straps.polled;
      if (straps.polled) begin
        o_almost_full_bus_own <= (next_state == AFS_ST_SCAN) ||
                                 (state == AFS_ST_SCAN);
      end else if (dir_load) begin
        o_almost_full_bus_own <= o_write_sel.hit;
      end
    end
  end

  // Steps of one polled scan.
  sequence s_quad_two;
    shown_quad == 2'h1;
  endsequence

  sequence s_quad_three;
    shown_quad == 2'h2;
  endsequence

  sequence s_quad_four_token;
    (shown_quad == AFS_QUAD_LAST) && o_full_side_token_out;
  endsequence

  property p_sync_one_cycle;
    @(posedge i_clk) disable iff (!i_rstn)
      o_full_side_scan_sync |=> !o_full_side_scan_sync;
  endproperty
  a_sync_one_cycle: assert property (p_sync_one_cycle) else $error("Sync longer than one cycle.");

  property p_token_one_cycle;
    @(posedge i_clk) disable iff (!i_rstn)
      o_full_side_token_out |=> !o_full_side_token_out;
  endproperty
  a_token_one_cycle: assert property (p_token_one_cycle) else $error("Token longer than one cycle.");

  property p_sync_quad_one;
    @(posedge i_clk) disable iff (!i_rstn)
      o_full_side_scan_sync |-> (shown_quad == AFS_QUAD_FIRST) && o_polled_mode;
  endproperty
  a_sync_quad_one: assert property (p_sync_quad_one) else $error("Sync without quadrant one.");

  property p_scan_walk;
    @(posedge i_clk) disable iff (!i_rstn)
      o_full_side_scan_sync |=> s_quad_two ##1 s_quad_three ##1 s_quad_four_token;
  endproperty
  a_scan_walk: assert property (p_scan_walk) else $error("Polled scan out of sequence.");

  property p_token_after_last;
    @(posedge i_clk) disable iff (!i_rstn)
      o_full_side_token_out |-> (shown_quad == AFS_QUAD_LAST) && $past(state == AFS_ST_SCAN);
  endproperty
  a_token_after_last: assert property (p_token_after_last) else $error("Token without last quadrant.");

  property p_token_starts;
    @(posedge i_clk) disable iff (!i_rstn)
      (straps.polled && straps_valid && state == AFS_ST_WAIT && token_rise) |=>
        o_full_side_scan_sync;
  endproperty
  a_token_starts: assert property (p_token_starts) else $error("Token did not start scan.");

  property p_direct_select;
    @(posedge i_clk) disable iff (!i_rstn)
      (dir_load && o_write_sel.hit) |=>
        shown_quad == $past(o_write_sel.index[AFS_QIDX_W-1:AFS_QUAD_LSB]) &&
        o_almost_full_bus_own;
  endproperty
  a_direct_select: assert property (p_direct_select) else $error("Direct quadrant not shown.");

  property p_mode_capture;
    @(posedge i_clk) disable iff (!i_rstn)
      $rose(straps_valid) |-> straps.polled == $past(mode_s) && straps.id == $past(id_s);
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("Straps not captured.");

  property p_id_stable;
    @(posedge i_clk) disable iff (!i_rstn)
      straps_valid |=> $stable(straps) && straps_valid;
  endproperty
  a_id_stable: assert property (p_id_stable) else $error("Captured straps changed.");

endmodule // afs_flag_scan

// ### sim/afs_chain_peer.sv
// Model of the neighbour on the token ring: a wire loop or a preceding device.
`timescale 1ns/1ps
module afs_chain_peer (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Bench control: loop the token back, or send one token pulse.
  input wire logic i_loop,
  input wire logic i_send,
  // Token pins of the device under test.
  input wire logic i_token_from_dut,
  output logic o_token_to_dut
);
  logic send_q;

  // A preceding device launches its token just after a clock edge, one cycle long.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      send_q <= 1'b0;
    end else begin
      send_q <= i_send;
    end
  end

  // Single device: output tied back to input; otherwise the input is held low
  // unless a preceding device passes its token.
  assign o_token_to_dut = i_loop ? i_token_from_dut : send_q;
endmodule // afs_chain_peer

// ### sim/tb_afs_flag_scan.sv
// Self-checking testbench of the almost-full flag bus scanner.
`timescale 1ns/1ps
module tb_afs_flag_scan import afs_pkg::*; ;
  logic i_clk, i_rstn, mode, master, strobe, pdone, loop, send;
  logic [2:0] idp;
  logic [7:0] waddr, raddr, bus;
  logic [31:0] flags;
  logic own, sync, tok_out, tok_in, polled;
  afs_qsel_t wsel, rsel;
  int n_mismatch, n_compared, k;

  afs_flag_scan afs_flag_scan_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_flag_bus_mode_sel(mode),
    .i_master_device(master), .i_chain_identity_pins(idp),
    .i_full_side_quadrant_strobe(strobe), .i_full_side_token_in(tok_in),
    .i_write_queue_addr(waddr), .i_read_queue_addr(raddr), .i_almost_full_flags(flags),
    .i_program_done(pdone), .o_almost_full_status_bus(bus), .o_almost_full_bus_own(own),
    .o_full_side_scan_sync(sync), .o_full_side_token_out(tok_out), .o_polled_mode(polled),
    .o_write_sel(wsel), .o_read_sel(rsel));

  afs_chain_peer afs_chain_peer_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_loop(loop),
    .i_send(send), .i_token_from_dut(tok_out), .o_token_to_dut(tok_in));

  // Clock at 25 MHz.
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Inputs always change one nanosecond after the rising edge.
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // Straps are set before release and held; the strobe stays low in reset.
  task automatic rst(input logic m, input logic ms, input logic [2:0] id, input logic lp);
    i_rstn = 1'b0;
    mode = m;
    master = ms;
    idp = id;
    loop = lp;
    strobe = 1'b0;
    repeat (5) step();
    i_rstn = 1'b1;
    repeat (5) step();
  endtask

  // Walks one polled scan that has just raised sync; wrap says quadrant one returns at once.
  task automatic scan_walk(input logic wrap);
    chk(32'h1, sync);
    chk(32'hD1, bus);
    chk(32'h1, own);
    step();
    chk(32'hC2, bus);
    chk(32'h0, sync);
    step();
    chk(32'hB3, bus);
    step();
    chk(32'hA4, bus);
    chk(32'h1, tok_out);
    step();
    chk(32'h0, tok_out);
    chk({31'h0, wrap}, sync);
  endtask

  // Single master device with its token looped back to itself.
  task automatic t_polled_master();
    rst(1'b1, 1'b1, 3'h0, 1'b1);
    chk(32'h1, polled);
    for (k = 0; k < 20 && sync !== 1'b1; k++) step();
    scan_walk(1'b1);
    for (k = 0; k < 10 && sync !== 1'b1; k++) step();
    chk(32'hD1, bus);
    chk(32'h1, sync);
    $display("test polled_master done");
  endtask

  // Slave device: it scans only when a token arrives from the previous device.
  task automatic t_polled_token();
    rst(1'b1, 1'b0, 3'h3, 1'b0);
    for (k = 0; k < 10; k++) begin
      step();
      chk(32'h0, sync);
    end
    send = 1'b1;
    step();
    send = 1'b0;
    for (k = 0; k < 8 && sync !== 1'b1; k++) step();
    scan_walk(1'b0);
    for (k = 0; k < 10; k++) begin
      step();
      chk(32'h0, sync);
    end
    $display("test polled_token done");
  endtask

  // Direct mode: every quadrant back to back, then an identity miss and no programming.
  task automatic t_direct();
    rst(1'b0, 1'b1, 3'h6, 1'b0);
    chk(32'h0, polled);
    for (int q = 0; q < 4; q++) begin
      waddr = {3'h6, q[1:0], 3'h5};
      strobe = 1'b1;
      repeat (4) step();
      chk(flags[8*q +: 8], bus);
      chk(32'h1, own);
    end
    waddr = {3'h1, 2'h2, 3'h0};
    repeat (6) step();
    chk(32'h0, own);
    strobe = 1'b0;
    pdone = 1'b0;
    step();
    waddr = {3'h6, 2'h1, 3'h0};
    strobe = 1'b1;
    repeat (6) step();
    chk(32'h0, own);
    strobe = 1'b0;
    // Let the strobe pipeline drain before programming completes, so nothing is replayed.
    repeat (4) step();
    pdone = 1'b1;
    step();
    for (k = 0; k < 8; k++) begin
      step();
      chk(32'h0, sync);
    end
    chk(32'h0, own);
    chk(flags[31:24], bus);
    $display("test direct done");
  endtask

  // Address decode on both buses with identity 7; later pin changes are ignored.
  task automatic t_decode();
    rst(1'b0, 1'b0, 3'h7, 1'b0);
    for (int i = 0; i < 4; i++) begin
      waddr = {3'h7, 5'(i * 9 + 1)};
      raddr = {3'(i), 5'(i * 7)};
      repeat (4) step();
      chk({26'h0, 1'b1, 5'(i * 9 + 1)}, 32'(wsel));
      chk(32'h0, 32'(rsel.hit));
      waddr = {3'(i + 2), 5'h1F};
      raddr = {3'h7, 5'(i * 7)};
      repeat (4) step();
      chk(32'h0, 32'(wsel.hit));
      chk({26'h0, 1'b1, 5'(i * 7)}, 32'(rsel));
    end
    idp = 3'h0;
    repeat (4) step();
    chk({26'h0, 1'b1, 5'h15}, 32'(rsel));
    idp = 3'h7;
    $display("test decode done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    #(40 * 5000);
    n_mismatch++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    i_rstn = 1'b0;
    mode = 1'b0;
    master = 1'b0;
    idp = 3'h0;
    strobe = 1'b0;
    loop = 1'b0;
    send = 1'b0;
    pdone = 1'b1;
    waddr = 8'h00;
    raddr = 8'h00;
    flags = 32'hA4B3C2D1;
    t_polled_master();
    t_polled_token();
    t_direct();
    t_decode();
    tally_and_finish();
  end
endmodule // tb_afs_flag_scan
